// [design/bps_sequencer.v]
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "bps_map.vh"
module bps_sequencer #(
  parameter RESTART_CYCLES = `BPS_RESTART_CYC,
  parameter DELAY_STEP_CYC = `BPS_DELAY_STEP_CYC,
  parameter WAKE_CYCLES    = `BPS_WAKE_CYC,
  parameter INIT_CYCLES    = `BPS_INIT_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        supply_above_lockout,
  input  wire        en_pin,
  input  wire        power_supply_ok,
  input  wire [3:0]  peak_cmp,
  input  wire        neg_limit_event,
  input  wire        switch_cycle_tick,
  input  wire        output_valid,
  input  wire        thermal_hot,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire        converter_enable,
  output wire        high_side_allow,
  output reg         discharge_on,
  output reg         seq_start,
  output reg  [3:0]  seq_kind,
  output wire [1:0]  mode_state,
  output wire        serial_inactive,
  output wire        pfm_allowed,
  output reg  [7:0]  ramp_level,
  output wire        ramp_active,
  output wire        ramp_forced_pwm,
  output reg         thermal_source
);
  // ****************************************************************
  // reset and state encoding
  // ****************************************************************
  // lockout acts as reset for everything, registers included
  wire rst = ~aresetn | ~supply_above_lockout;

  localparam [6:0] ST_WAKE  = 7'h01;
  localparam [6:0] ST_IDLE  = 7'h02;
  localparam [6:0] ST_DELAY = 7'h04;
  localparam [6:0] ST_INIT  = 7'h08;
  localparam [6:0] ST_RUN   = 7'h10;
  localparam [6:0] ST_HOLD  = 7'h20;
  localparam [6:0] ST_LATCH = 7'h40;

  localparam [3:0] KIND_INITIAL = 4'h1;
  localparam [3:0] KIND_NORMAL  = 4'h2;
  localparam [3:0] KIND_QUICK   = 4'h4;
  localparam [3:0] KIND_FAST    = 4'h8;

  localparam [1:0] MODE_OFF   = 2'd0;
  localparam [1:0] MODE_SLEEP = 2'd1;
  localparam [1:0] MODE_ON    = 2'd2;

  // ****************************************************************
  // registers
  // ****************************************************************
  reg  [4:0]  cmd;
  reg  [2:0]  lim;
  reg  [3:0]  tim;
  reg  [7:0]  output_program_reg;
  reg         short_fault_flag;
  reg         thermal_flag;
  reg  [6:0]  state;
  reg  [31:0] timer;
  reg         en_prev;
  reg         enable_prev;
  reg         initial_startup_seq_pending;
  reg  [1:0]  mode_prev;
  reg  [1:0]  peak_count;
  reg  [3:0]  neg_count;
  reg         neg_seen;
  reg         hs_block;
  reg         output_program_reg_written;
  reg  [15:0] ramp_div;

  wire enable_bit            = cmd[`BPS_CMD_ENABLE];
  wire sleep_hold            = cmd[`BPS_CMD_SLEEP];
  wire output_discharge_enable = cmd[`BPS_CMD_DISCH];
  wire forced_pwm            = cmd[`BPS_CMD_FPWM];
  wire ramp_mode_select      = cmd[`BPS_CMD_RMODE];
  wire [1:0] peak_sel        = lim[`BPS_LIM_PEAK_LO +: 2];
  wire auto_restart_enable   = lim[`BPS_LIM_AUTO_RESTART_ENABLE];
  wire [1:0] delay_sel       = tim[`BPS_TIME_DLY_LO +: 2];
  wire [1:0] ramp_rate_select = tim[`BPS_TIME_RATE_LO +: 2];

  // ****************************************************************
  // mode resolution
  // ****************************************************************
  // pin low picks OFF or SLEEP by sleep-hold, pin high by enable bit
  assign mode_state = ~en_pin ? (sleep_hold ? MODE_SLEEP : MODE_OFF)
                    : (enable_bit ? MODE_ON : MODE_SLEEP);
  wire run_request = en_pin & enable_bit;
  wire en_rise     = en_pin & ~en_prev;
  wire enable_rise = enable_bit & ~enable_prev;
  wire waking      = state[0];

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  reg        aw_held;
  reg        w_held;
  reg [3:0]  aw_addr;
  reg [31:0] w_data;
  reg        w_lane0;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire [3:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire        wr_lane = w_held ? w_lane0 : s_axi_wstrb[0];
  wire have_aw = aw_held | (s_axi_awvalid & s_axi_awready);
  wire have_w  = w_held | (s_axi_wvalid & s_axi_wready);
  wire wr_fire = have_aw & have_w;
  // writes are refused while waking; only the low byte holds fields
  wire wr_ok   = wr_fire & ~waking & wr_lane;
  wire wr_map  = wr_addr <= `BPS_STAT_OFS;
  wire rd_fire = s_axi_arvalid & s_axi_arready;

  // address and data channels captured independently
  always @(posedge aclk) begin
    if (rst) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 4'h0;
      w_data       <= 32'h0000_0000;
      w_lane0      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BPS_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (waking | ~wr_map) ? `BPS_RESP_SLVERR
                        : `BPS_RESP_OKAY;
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_held  <= 1'b1;
          w_data  <= s_axi_wdata;
          w_lane0 <= s_axi_wstrb[0];
        end
        if (s_axi_bvalid & s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data mux, refused during wake-up
  reg [31:0] rd_mux;
  always @* begin
    case (s_axi_araddr)
      `BPS_CMD_OFS:  rd_mux = {27'h0, cmd};
      `BPS_LIM_OFS:  rd_mux = {29'h0, lim};
      `BPS_TIME_OFS: rd_mux = {28'h0, tim};
      `BPS_OUTPUT_PROGRAM_REG_OFS: rd_mux = {24'h0, output_program_reg};
      `BPS_FLAG_OFS: rd_mux = {30'h0, thermal_flag, short_fault_flag};
      `BPS_STAT_OFS: rd_mux = {ramp_level, 5'h0, state, seq_kind,
                               6'h0, mode_state};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge aclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `BPS_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= waking ? 32'h0000_0000 : rd_mux;
      s_axi_rresp  <= (waking | (s_axi_araddr > `BPS_STAT_OFS))
                      ? `BPS_RESP_SLVERR : `BPS_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign serial_inactive = waking;

  // ****************************************************************
  // control registers
  // ****************************************************************
  // registers survive faults; only lockout or reset returns defaults
  always @(posedge aclk) begin
    if (rst) begin
      cmd          <= `BPS_CMD_RST;
      lim          <= `BPS_LIM_RST;
      tim          <= `BPS_TIME_RST;
      output_program_reg         <= `BPS_OUTPUT_PROGRAM_REG_RST;
      output_program_reg_written <= 1'b0;
    end else begin
      output_program_reg_written <= 1'b0;
      if (wr_ok) begin
        case (wr_addr)
          `BPS_CMD_OFS:  cmd <= wr_data[4:0];
          `BPS_LIM_OFS:  lim <= wr_data[2:0];
          `BPS_TIME_OFS: tim <= wr_data[3:0];
          `BPS_OUTPUT_PROGRAM_REG_OFS: begin
            output_program_reg         <= wr_data[7:0];
            output_program_reg_written <= wr_data[7:0] != output_program_reg;
          end
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // fault detection
  // ****************************************************************
  wire running   = state[4];
  wire peak_now  = peak_cmp[peak_sel];
  wire peak_evt  = running & peak_now & ~hs_block;
  wire peak_trip = peak_evt & ~output_valid
                   & (peak_count == `BPS_PEAK_FAULTS - 2'd1);
  wire neg_trip  = running & neg_limit_event
                   & (neg_count == `BPS_NEG_FAULTS - 4'd1);
  wire therm_trip = running & thermal_hot;
  wire cur_fault = peak_trip | neg_trip;

  // high-side blocked from a peak until the next switching cycle
  always @(posedge aclk) begin
    if (rst)
      hs_block <= 1'b0;
    else if (switch_cycle_tick)
      hs_block <= 1'b0;
    else if (peak_now)
      hs_block <= 1'b1;
  end
  assign high_side_allow = running & power_supply_ok & ~peak_now
                           & ~hs_block;

  // counters live only inside one run
  always @(posedge aclk) begin
    if (rst | ~running | cur_fault) begin
      peak_count <= 2'd0;
      neg_count  <= 4'd0;
      neg_seen   <= 1'b0;
    end else begin
      if (peak_evt & ~output_valid)
        peak_count <= peak_count + 2'd1;
      if (neg_limit_event) begin
        neg_count <= neg_count + 4'd1;
        neg_seen  <= 1'b1;
      end else if (switch_cycle_tick) begin
        // a clean switching cycle breaks the run of events
        if (~neg_seen)
          neg_count <= 4'd0;
        neg_seen <= 1'b0;
      end
    end
  end

  // sticky flags: hardware set wins over a write-one clear
  wire flag_wr = wr_ok & (wr_addr == `BPS_FLAG_OFS);
  always @(posedge aclk) begin
    if (rst) begin
      short_fault_flag <= 1'b0;
      thermal_flag     <= 1'b0;
      thermal_source   <= 1'b0;
    end else begin
      thermal_source <= running & thermal_hot;
      if (cur_fault)
        short_fault_flag <= 1'b1;
      else if (flag_wr & wr_data[`BPS_FLAG_SHORT])
        short_fault_flag <= 1'b0;
      if (therm_trip)
        thermal_flag <= 1'b1;
      else if (flag_wr & wr_data[`BPS_FLAG_THERM])
        thermal_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // power sequencer
  // ****************************************************************
  wire [31:0] delay_cyc = delay_sel * DELAY_STEP_CYC;
  wire        timer_done = timer == 32'd0;

  always @(posedge aclk) begin
    if (rst) begin
      state        <= ST_WAKE;
      timer        <= WAKE_CYCLES - 1;
      en_prev      <= 1'b0;
      enable_prev  <= 1'b0;
      initial_startup_seq_pending <= 1'b0;
      mode_prev    <= MODE_OFF;
      seq_start    <= 1'b0;
      seq_kind     <= 4'h0;
    end else begin
      en_prev     <= en_pin;
      enable_prev <= enable_bit;
      mode_prev   <= mode_state;
      seq_start   <= 1'b0;
      if (~timer_done)
        timer <= timer - 32'd1;
      case (state)
        ST_WAKE: begin
          // interval runs to the end whatever the pin does
          if (en_rise)
            initial_startup_seq_pending <= 1'b1;
          if (timer_done)
            state <= ST_IDLE;
        end
        ST_IDLE: begin
          if (run_request & power_supply_ok & ~thermal_hot) begin
            if (initial_startup_seq_pending | (en_rise & mode_prev == MODE_OFF)) begin
              seq_kind <= initial_startup_seq_pending ? KIND_INITIAL
                          : KIND_NORMAL;
              timer    <= delay_cyc;
              state    <= ST_DELAY;
            end else if (en_rise) begin
              seq_kind <= KIND_QUICK;
              timer    <= delay_cyc;
              state    <= ST_DELAY;
            end else begin
              seq_kind <= KIND_FAST;
              timer    <= INIT_CYCLES - 1;
              state    <= ST_INIT;
            end
            initial_startup_seq_pending <= 1'b0;
          end else if (~en_pin) begin
            initial_startup_seq_pending <= 1'b0;
          end
        end
        ST_DELAY: begin
          if (~run_request)
            state <= ST_IDLE;
          else if (timer_done) begin
            timer <= INIT_CYCLES - 1;
            state <= ST_INIT;
          end
        end
        ST_INIT: begin
          if (~run_request)
            state <= ST_IDLE;
          else if (timer_done) begin
            seq_start <= 1'b1;
            state     <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (~run_request)
            state <= ST_IDLE;
          else if (~power_supply_ok) begin
            // back through a fast start once the supply recovers
            seq_kind <= KIND_FAST;
            state    <= ST_IDLE;
          end else if (cur_fault | therm_trip) begin
            timer <= RESTART_CYCLES - 1;
            state <= auto_restart_enable ? ST_HOLD
                     : ST_LATCH;
          end
        end
        ST_HOLD: begin
          // thermal recovery also waits for the die to cool
          if (timer_done & ~thermal_hot) begin
            seq_kind <= KIND_FAST;
            timer    <= INIT_CYCLES - 1;
            state    <= ST_INIT;
          end
        end
        ST_LATCH: begin
          // a low pin returns to idle; the next rise restarts
          if (~en_pin)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign converter_enable = running & power_supply_ok;

  // discharge path, forced through wake-up
  always @(posedge aclk) begin
    if (rst)
      discharge_on <= 1'b1;
    else
      discharge_on <= waking | (~running & output_discharge_enable);
  end

  // ****************************************************************
  // voltage ramp
  // ****************************************************************
  reg [15:0] ramp_period;
  always @* begin
    case (ramp_rate_select)
      2'd0:    ramp_period = `BPS_RAMP_CYC0;
      2'd1:    ramp_period = `BPS_RAMP_CYC1;
      2'd2:    ramp_period = `BPS_RAMP_CYC2;
      default: ramp_period = `BPS_RAMP_CYC3;
    endcase
  end
  wire ramp_up   = ramp_level < output_program_reg;
  wire ramp_tick = ramp_div == 16'd0;
  assign ramp_active = ramp_level != output_program_reg;

  // one level step per period; down steps never outrun the rate
  always @(posedge aclk) begin
    if (rst) begin
      ramp_level <= `BPS_OUTPUT_PROGRAM_REG_RST;
      ramp_div   <= 16'd0;
    end else if (output_program_reg_written | ~ramp_active) begin
      ramp_div <= ramp_period - 16'd1;
    end else if (ramp_tick) begin
      ramp_div   <= ramp_period - 16'd1;
      ramp_level <= ramp_up ? ramp_level + 8'd1
                    : ramp_level - 8'd1;
    end else begin
      ramp_div <= ramp_div - 16'd1;
    end
  end
  assign ramp_forced_pwm = ramp_active & (ramp_mode_select | ramp_up);
  assign pfm_allowed     = ~forced_pwm & ~ramp_forced_pwm;
endmodule

// [include/bps_map.vh]
`ifndef BPS_MAP_VH
`define BPS_MAP_VH
// ****************************************************************
// clock and timing
// ****************************************************************
`define BPS_CLK_MHZ        100
`define BPS_RESTART_US     2000
`define BPS_RESTART_CYC    (`BPS_RESTART_US * `BPS_CLK_MHZ)
`define BPS_DELAY_STEP_US  2000
`define BPS_DELAY_STEP_CYC (`BPS_DELAY_STEP_US * `BPS_CLK_MHZ)
`define BPS_WAKE_US        300
`define BPS_WAKE_CYC       (`BPS_WAKE_US * `BPS_CLK_MHZ)
`define BPS_INIT_US        50
`define BPS_INIT_CYC       (`BPS_INIT_US * `BPS_CLK_MHZ)
// ramp step periods per rate code, in cycles
`define BPS_RAMP_CYC0      16'd400
`define BPS_RAMP_CYC1      16'd200
`define BPS_RAMP_CYC2      16'd100
`define BPS_RAMP_CYC3      16'd50
// fault thresholds
`define BPS_PEAK_FAULTS    2'd2
`define BPS_NEG_FAULTS     4'd8
// ****************************************************************
// register offsets
// ****************************************************************
`define BPS_CMD_OFS        4'h0
`define BPS_LIM_OFS        4'h1
`define BPS_TIME_OFS       4'h2
`define BPS_OUTPUT_PROGRAM_REG_OFS       4'h3
`define BPS_FLAG_OFS       4'h4
`define BPS_STAT_OFS       4'h5
// command fields
`define BPS_CMD_ENABLE     0
`define BPS_CMD_SLEEP      1
`define BPS_CMD_DISCH      2
`define BPS_CMD_FPWM       3
`define BPS_CMD_RMODE      4
// limit config fields
`define BPS_LIM_PEAK_LO    0
`define BPS_LIM_AUTO_RESTART_ENABLE      2
// time fields
`define BPS_TIME_DLY_LO    0
`define BPS_TIME_RATE_LO   2
// flag fields
`define BPS_FLAG_SHORT     0
`define BPS_FLAG_THERM     1
// reset values
`define BPS_CMD_RST        5'h00
`define BPS_LIM_RST        3'h1
`define BPS_TIME_RST       4'h0
`define BPS_OUTPUT_PROGRAM_REG_RST       8'h64
// axi responses
`define BPS_RESP_OKAY      2'b00
`define BPS_RESP_SLVERR    2'b10
`endif

// [dv/bps_checker.sv]
`timescale 1ns/1ns
// ****************************************************************
// protection and sequencing checker
// ****************************************************************
module bps_checker (
  input wire       aclk,
  input wire       aresetn,
  input wire       supply_above_lockout,
  input wire       en_pin,
  input wire       power_supply_ok,
  input wire [3:0] peak_cmp,
  input wire       thermal_hot,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire [1:0] s_axi_rresp,
  input wire       s_axi_rvalid,
  input wire       converter_enable,
  input wire       high_side_allow,
  input wire       discharge_on,
  input wire       seq_start,
  input wire [3:0] seq_kind,
  input wire [1:0] mode_state,
  input wire       serial_inactive,
  input wire       pfm_allowed,
  input wire       ramp_active,
  input wire       ramp_forced_pwm,
  input wire       thermal_source
);
  // lockout acts as a reset, so most checks pause while it is low
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !supply_above_lockout);
  sequence ar_in_wake;
    s_axi_arvalid && s_axi_arready && serial_inactive;
  endsequence
  sequence hot_run;
    converter_enable && thermal_hot;
  endsequence
  a_peak_blocks: assert property (
    peak_cmp == 4'hf |-> !high_side_allow) else $error("peak not blocked");
  a_supply_stop: assert property (
    !power_supply_ok |-> !converter_enable && !high_side_allow)
    else $error("switching without supply");
  a_pin_low_mode: assert property (
    !en_pin |-> mode_state != 2'd2) else $error("on with pin low");
  a_run_mode_on: assert property (
    mode_state != 2'd2 |=> !converter_enable) else $error("run not on");
  a_pin_fall_off: assert property (
    $fell(en_pin) |-> ##[0:2] !converter_enable)
    else $error("pin low kept running");
  a_wake_discharge: assert property (
    serial_inactive |-> discharge_on) else $error("no wake discharge");
  a_wake_nack: assert property (
    ar_in_wake |=> s_axi_rvalid && s_axi_rresp == 2'b10)
    else $error("bus answered in wake");
  a_lockout_reset: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !supply_above_lockout |=> serial_inactive && discharge_on)
    else $error("lockout not reset");
  a_start_pulse: assert property (
    seq_start |-> $onehot(seq_kind) ##1 !seq_start)
    else $error("bad start pulse");
  a_thermal_off: assert property (
    hot_run |-> ##[1:3] !converter_enable) else $error("hot and running");
  a_thermal_cause: assert property (
    thermal_source |-> $past(thermal_hot)) else $error("thermal no cause");
  a_ramp_fpwm: assert property (
    ramp_forced_pwm |-> ramp_active && !pfm_allowed)
    else $error("forced ramp wrong");
endmodule
bind bps_sequencer bps_checker chk_i (.*);

// [dv/bps_host.sv]
`timescale 1ns/1ns
// ****************************************************************
// host model: register bus master and enable pin
// ****************************************************************
module bps_host (
  input  wire        aclk,
  output reg         en_pin,
  output reg  [3:0]  s_axi_awaddr,
  output reg         s_axi_awvalid,
  input  wire        s_axi_awready,
  output reg  [31:0] s_axi_wdata,
  output reg  [3:0]  s_axi_wstrb,
  output reg         s_axi_wvalid,
  input  wire        s_axi_wready,
  input  wire [1:0]  s_axi_bresp,
  input  wire        s_axi_bvalid,
  output reg         s_axi_bready,
  output reg  [3:0]  s_axi_araddr,
  output reg         s_axi_arvalid,
  input  wire        s_axi_arready,
  input  wire [31:0] s_axi_rdata,
  input  wire [1:0]  s_axi_rresp,
  input  wire        s_axi_rvalid,
  output reg         s_axi_rready,
  output reg         bus_stuck
);
  // pin pulled down, bus idle at time zero
  initial begin
    {en_pin, bus_stuck, s_axi_awaddr, s_axi_araddr} = 10'h000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready, s_axi_wdata} = 34'h0;
    s_axi_wstrb = 4'hf;
  end
  // shutdown and restart toggles come only from here
  task pin(input v);
    en_pin <= v;
  endtask
  // write: channels released one by one as each is taken
  task wr(input [3:0] a, input [31:0] d, output [1:0] r);
    integer n;
    reg     awk, wk, bk;
    begin
      {awk, wk, bk, r} = 5'h03;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      for (n = 0; n < 60 && !bk; n = n + 1) begin
        @(posedge aclk);
        if (awk && wk && s_axi_bvalid) begin
          bk = 1'b1;
          r = s_axi_bresp;
          s_axi_bready <= 1'b0;
        end
        if (s_axi_awvalid && s_axi_awready) begin
          awk = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          wk = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
      end
      if (!bk) bus_stuck <= 1'b1;
      @(posedge aclk);
    end
  endtask
  // read: address held until taken, data taken with rvalid
  task rd(input [3:0] a, output [31:0] d, output [1:0] r);
    integer n;
    reg     ak, rk;
    begin
      {ak, rk, r, d} = 36'h3;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      for (n = 0; n < 60 && !rk; n = n + 1) begin
        @(posedge aclk);
        if (ak && s_axi_rvalid) begin
          rk = 1'b1;
          {d, r} = {s_axi_rdata, s_axi_rresp};
          s_axi_rready <= 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
          ak = 1'b1;
          s_axi_arvalid <= 1'b0;
        end
      end
      if (!rk) bus_stuck <= 1'b1;
      @(posedge aclk);
    end
  endtask
endmodule

// [dv/bps_sequencer_tb.sv]
`timescale 1ns/1ns
// ****************************************************************
// bench top
// ****************************************************************
module bps_sequencer_tb;
  reg         aclk, aresetn, supply_above_lockout, power_supply_ok;
  reg         neg_limit_event, switch_cycle_tick, output_valid;
  reg         thermal_hot;
  reg  [3:0]  peak_cmp;
  wire        en_pin, bus_stuck, s_axi_awready, s_axi_wready, s_axi_bready;
  wire        s_axi_awvalid, s_axi_wvalid, s_axi_bvalid, s_axi_arvalid;
  wire        s_axi_arready, s_axi_rvalid, s_axi_rready, converter_enable;
  wire        high_side_allow, discharge_on, seq_start, serial_inactive;
  wire        pfm_allowed, ramp_active, ramp_forced_pwm, thermal_source;
  wire [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, seq_kind;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [1:0]  s_axi_bresp, s_axi_rresp, mode_state;
  wire [7:0]  ramp_level;
  integer     failures, checks, i, n;
  integer     mdl [0:4];
  reg  [31:0] d;
  reg  [1:0]  r;
  // short counts keep the run brief
  bps_sequencer #(.RESTART_CYCLES(20), .DELAY_STEP_CYC(10),
    .WAKE_CYCLES(8), .INIT_CYCLES(4)) uut (.*);
  bps_host host (.*);
  always #5 aclk = ~aclk;
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      if (failures == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // bounded wait for a start pulse, n edges counted
  task wstart(input integer lim);
    begin
      for (n = 0; n < lim && seq_start !== 1'b1; n = n + 1)
        @(posedge aclk);
      if (n >= lim) begin
        failures = failures + 1;
        test_done;
      end
    end
  endtask
  // one switching cycle carrying a peak or a negative event
  task ev(input [3:0] pk);
    begin
      switch_cycle_tick <= 1'b1;
      @(posedge aclk);
      switch_cycle_tick <= 1'b0;
      if (pk != 4'h0) peak_cmp <= pk;
      else neg_limit_event <= 1'b1;
      @(posedge aclk);
      {peak_cmp, neg_limit_event} <= 5'h00;
      @(posedge aclk);
    end
  endtask
  always @(posedge bus_stuck) begin
    failures = failures + 1;
    test_done;
  end
  initial begin
    {failures, checks} = 0;
    {aclk, aresetn, neg_limit_event, switch_cycle_tick} = 4'h0;
    {output_valid, thermal_hot, peak_cmp} = 6'h00;
    {supply_above_lockout, power_supply_ok} = 2'b11;
    {mdl[0], mdl[1], mdl[2]} = {32'd0, 32'd1, 32'd0};
    {mdl[3], mdl[4]} = {32'h64, 32'd0};
    d = $urandom(4);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    host.rd(4'h0, d, r);
    chk(r, 2'b10);
    for (n = 0; n < 40 && serial_inactive !== 1'b0; n = n + 1)
      @(posedge aclk);
    if (n >= 40) begin
      failures = failures + 1;
      test_done;
    end
    chk(mode_state, 2'd0);
    for (i = 0; i < 7; i = i + 1) begin
      host.rd(i[3:0], d, r);
      chk(r, (i > 5) ? 2'b10 : 2'b00);
      if (i < 5) chk(d, mdl[i]);
    end
    mdl[3] = $urandom % 100;
    host.wr(4'h3, mdl[3], r);
    chk(r, 2'b00);
    chk({ramp_active, ramp_forced_pwm, pfm_allowed, ramp_level},
        11'h564);
    host.pin(1'b1);
    repeat (2) @(posedge aclk);
    chk(mode_state, 2'd1);
    mdl[0] = 1;
    host.wr(4'h0, 32'h1, r);
    wstart(40);
    chk(seq_kind, 4'h8);
    @(posedge aclk);
    chk({converter_enable, mode_state}, 3'b110);
    // latched peak fault, then pin toggle from off
    output_valid <= 1'b1;
    ev(4'hf);
    output_valid <= 1'b0;
    ev(4'h1);
    ev(4'hf);
    chk(converter_enable, 1'b1);
    ev(4'hf);
    mdl[4] = 1;
    repeat (3) @(posedge aclk);
    chk(converter_enable, 1'b0);
    host.rd(4'h4, d, r);
    chk(d, mdl[4]);
    repeat (40) @(posedge aclk);
    chk(converter_enable, 1'b0);
    host.pin(1'b0);
    repeat (2) @(posedge aclk);
    host.pin(1'b1);
    wstart(60);
    chk(seq_kind, 4'h2);
    host.wr(4'h4, 32'h1, r);
    mdl[4] = 0;
    host.rd(4'h4, d, r);
    chk(d, mdl[4]);
    // automatic restart after eight negative events
    host.wr(4'h1, 32'h5, r);
    repeat (8) ev(4'h0);
    mdl[4] = 1;
    repeat (2) @(posedge aclk);
    chk(converter_enable, 1'b0);
    wstart(80);
    chk(seq_kind, 4'h8);
    chk(n > 20, 1'b1);
    host.rd(4'h3, d, r);
    chk(d, mdl[3]);
    power_supply_ok <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(converter_enable, 1'b0);
    power_supply_ok <= 1'b1;
    wstart(40);
    chk(seq_kind, 4'h8);
    thermal_hot <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(converter_enable, 1'b0);
    thermal_hot <= 1'b0;
    mdl[4] = 3;
    host.rd(4'h4, d, r);
    chk(d, mdl[4]);
    wstart(80);
    // sleep hold, then a quick start with one delay step
    host.wr(4'h2, 32'h1, r);
    host.wr(4'h0, 32'hf, r);
    host.pin(1'b0);
    repeat (3) @(posedge aclk);
    chk({mode_state, converter_enable, discharge_on, pfm_allowed},
        5'h0a);
    host.pin(1'b1);
    wstart(80);
    chk(seq_kind, 4'h4);
    chk(n >= 10, 1'b1);
    supply_above_lockout <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({serial_inactive, discharge_on}, 2'b11);
    test_done;
  end
endmodule
